// file: src/etsq_pkg.sv
`default_nettype none
package etsq_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ETSQ_NCH = 8;
    localparam int ETSQ_CHW = 3;
    localparam int ETSQ_NSRC = 128;
    localparam int ETSQ_SELW = 7;
    localparam int ETSQ_NEXT = ETSQ_NSRC - ETSQ_NCH;
    localparam int ETSQ_DW = 32;
    localparam int ETSQ_AW = 30;
    localparam int ETSQ_STORE_DEPTH = 4;
    localparam int ETSQ_STORE_IW = 2;
    localparam logic [1:0] ETSQ_WORD_LSB = 2'h0;
    localparam logic [ETSQ_DW-1:0] ETSQ_ZERO = 32'h00000000;

    // ------------------------------------------------------------
    // Combining operations and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ETSQ_OP_XOR = 2'b00,
        ETSQ_OP_AND = 2'b01,
        ETSQ_OP_OR = 2'b10,
        ETSQ_OP_ADD = 2'b11
    } etsq_op_t;

    typedef enum logic [2:0] {
        ETSQ_ST_IDLE = 3'b000,
        ETSQ_ST_FETCH = 3'b001,
        ETSQ_ST_READ = 3'b010,
        ETSQ_ST_WRITE = 3'b011
    } etsq_state_t;
endpackage
`default_nettype wire

// file: src/etsq_store_if.sv
`default_nettype none
// Carries the data store write and read ports between sequencer and memory.
interface etsq_store_if;
    logic we;
    logic [etsq_pkg::ETSQ_STORE_IW-1:0] widx;
    logic [etsq_pkg::ETSQ_DW-1:0] wdata;
    logic [etsq_pkg::ETSQ_STORE_IW-1:0] ridx;
    logic [etsq_pkg::ETSQ_DW-1:0] rdata;
    modport user (output we, output widx, output wdata, output ridx, input rdata);
    modport mem (input we, input widx, input wdata, input ridx, output rdata);
endinterface
`default_nettype wire

// file: src/etsq_store.sv
`default_nettype none
module etsq_store
    import etsq_pkg::*;
(
    input wire logic i_core_clk, // Core clock.
    input wire logic i_rst,      // Asynchronous reset, active high.
    etsq_store_if.mem bus        // Store ports.
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ETSQ_STORE_DEPTH-1:0][ETSQ_DW-1:0] mem;
        logic [ETSQ_DW-1:0] rdata;
    } etsq_store_t;

    etsq_store_t s_r;
    etsq_store_t s_nxt;

    // Write on strobe; read data always come from a register.
    always_comb
    begin
        s_nxt = s_r;
        if (bus.we)
        begin
            s_nxt.mem[bus.widx] = bus.wdata;
        end
        s_nxt.rdata = s_r.mem[bus.ridx];
    end

    // State register.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus.rdata = s_r.rdata;
endmodule
`default_nettype wire

// file: src/etsq_sequencer.sv
`default_nettype none
module etsq_sequencer
    import etsq_pkg::*;
(
    input wire logic i_core_clk, // Core clock, 25 MHz.
    input wire logic i_rst, // Asynchronous reset, active high.
    input wire logic [etsq_pkg::ETSQ_NEXT-1:0] i_evt, // External event pulses, sources 0..119.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0] i_ch_en, // Channel armed.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0][etsq_pkg::ETSQ_SELW-1:0] i_ch_sel, // Source.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0] i_ch_rmw, // 1: read-modify-write, 0: write.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0][1:0] i_ch_op, // Combining operation.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0][etsq_pkg::ETSQ_AW-1:0] i_ch_addr, // Word address.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0][etsq_pkg::ETSQ_DW-1:0] i_ch_data, // Operand.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0] i_ch_use_store, // Operand from data store.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0][1:0] i_ch_store_idx, // Store word index.
    input wire logic i_store_we, // Data store write strobe.
    input wire logic [etsq_pkg::ETSQ_STORE_IW-1:0] i_store_idx, // Data store write index.
    input wire logic [etsq_pkg::ETSQ_DW-1:0] i_store_wdata, // Data store write data.
    input wire logic i_bus_ready, // Access finished this cycle.
    input wire logic [etsq_pkg::ETSQ_DW-1:0] i_bus_rdata, // Read data, valid with ready.
    output logic o_bus_req, // Access request, held until ready.
    output logic o_bus_write, // 1: write, 0: read.
    output logic o_bus_lock, // Bus held across read and write-back.
    output logic [etsq_pkg::ETSQ_DW-1:0] o_bus_addr, // Byte address, word aligned.
    output logic [etsq_pkg::ETSQ_DW-1:0] o_bus_wdata, // Write data.
    output logic [etsq_pkg::ETSQ_NCH-1:0] o_done // Completion pulses, sources 120..127.
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Everything the sequencer remembers outside the data store lives in one record: the task step,
    // the pending flags, the channel being served and the registered bus
    // outputs, so every output is a plain flip-flop.
    typedef struct packed {
        etsq_state_t st;
        logic [ETSQ_NCH-1:0] pend;
        logic [ETSQ_CHW-1:0] ch;
        logic req;
        logic wr;
        logic lock;
        logic [ETSQ_DW-1:0] addr;
        logic [ETSQ_DW-1:0] opnd;
        logic [ETSQ_DW-1:0] wdata;
        logic [ETSQ_NCH-1:0] done;
    } etsq_seq_t;

    etsq_seq_t s_r;
    etsq_seq_t s_nxt;
    etsq_store_if store_bus ();
    logic [ETSQ_NSRC-1:0] src;
    logic [ETSQ_NCH-1:0] fire;

    // ------------------------------------------------------------
    // Data store
    // ------------------------------------------------------------
    // Software-side writes; the sequencer reads the selected channel's word.
    // The read index follows the next channel number, so the word is registered
    // at the grant edge and stands ready when the operand is fetched.
    // A store write on the grant edge is not seen by that task; it needs one
    // more cycle.
    assign store_bus.we = i_store_we;
    assign store_bus.widx = i_store_idx;
    assign store_bus.wdata = i_store_wdata;
    assign store_bus.ridx = i_ch_store_idx[s_nxt.ch];

    etsq_store u_store (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .bus(store_bus)
    );

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    // Own completion pulses occupy the top eight source numbers.
    // A channel that selects its own completion re-arms itself after every task
    // and keeps the bus busy; software must avoid such a closed loop.
    assign src = {s_r.done, i_evt};

    // Each armed channel watches its own selected source.
    // A disabled channel ignores its source entirely.
    genvar g;
    generate
        for (g = 0; g < ETSQ_NCH; g++)
        begin : g_trig
            assign fire[g] = i_ch_en[g] & src[i_ch_sel[g]];
        end
    endgenerate

    // ------------------------------------------------------------
    // Combining function
    // ------------------------------------------------------------
    function automatic logic [ETSQ_DW-1:0] etsq_combine(
        input logic [1:0] op,
        input logic [ETSQ_DW-1:0] a,
        input logic [ETSQ_DW-1:0] b
    );
        logic [ETSQ_DW-1:0] res;
        res = a ^ b;
        case (etsq_op_t'(op))
            ETSQ_OP_XOR: res = a ^ b;
            ETSQ_OP_AND: res = a & b;
            ETSQ_OP_OR: res = a | b;
            ETSQ_OP_ADD: res = a + b; // Carry out is dropped: 32-bit wrap.
            default: res = a ^ b;
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Picks the lowest pending channel, fetches its operand, then runs the access.
    // Only one task is in flight, so the read and write-back of one channel can
    // never be split by another channel's access.
    always_comb
    begin
        logic [ETSQ_NCH-1:0] clr;
        logic [ETSQ_CHW-1:0] pick;
        logic [ETSQ_DW-1:0] opnd;
        clr = '0;
        pick = '0;
        opnd = ETSQ_ZERO;
        s_nxt = s_r;
        s_nxt.done = '0;
        // Scanning from the top down leaves the lowest pending number in pick.
        for (int i = ETSQ_NCH - 1; i >= 0; i--)
        begin
            if (s_r.pend[i])
            begin
                pick = ETSQ_CHW'(i);
            end
        end
        case (s_r.st)
            // Grant the bus to the winner and drop its pending flag.
            ETSQ_ST_IDLE:
            begin
                if (|s_r.pend)
                begin
                    s_nxt.ch = pick;
                    clr[pick] = 1'b1;
                    s_nxt.st = ETSQ_ST_FETCH;
                end
            end
            // Latch address and operand, then raise the request.
            // Configuration is read live, so a channel's settings must stay still while it runs.
            ETSQ_ST_FETCH:
            begin
                opnd = i_ch_use_store[s_r.ch] ? store_bus.rdata : i_ch_data[s_r.ch];
                s_nxt.opnd = opnd;
                s_nxt.addr = {i_ch_addr[s_r.ch], ETSQ_WORD_LSB};
                s_nxt.req = 1'b1;
                if (i_ch_rmw[s_r.ch])
                begin
                    s_nxt.wr = 1'b0;
                    s_nxt.lock = 1'b1;
                    s_nxt.st = ETSQ_ST_READ;
                end
                else
                begin
                    s_nxt.wr = 1'b1;
                    s_nxt.wdata = opnd;
                    s_nxt.st = ETSQ_ST_WRITE;
                end
            end
            // Wait for the read data, then turn the access into the write-back.
            ETSQ_ST_READ:
            begin
                if (i_bus_ready)
                begin
                    // Lock stays high so no other channel slips in.
                    s_nxt.wr = 1'b1;
                    s_nxt.wdata = etsq_combine(i_ch_op[s_r.ch], i_bus_rdata, s_r.opnd);
                    s_nxt.st = ETSQ_ST_WRITE;
                end
            end
            // Finish the task and pulse its completion once the write is taken.
            // A stalled target keeps the request standing here for as long as it waits.
            ETSQ_ST_WRITE:
            begin
                if (i_bus_ready)
                begin
                    s_nxt.req = 1'b0;
                    s_nxt.wr = 1'b0;
                    s_nxt.lock = 1'b0;
                    s_nxt.done[s_r.ch] = 1'b1;
                    s_nxt.st = ETSQ_ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = ETSQ_ST_IDLE;
            end
        endcase
        // A trigger in the same cycle as the grant keeps the channel pending.
        s_nxt.pend = (s_r.pend & ~clr) | fire;
    end

    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    // State register.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    // The request and its qualifiers therefore change only on a clock edge.
    assign o_bus_req = s_r.req;
    assign o_bus_write = s_r.wr;
    assign o_bus_lock = s_r.lock;
    assign o_bus_addr = s_r.addr;
    assign o_bus_wdata = s_r.wdata;
    assign o_done = s_r.done;
endmodule
`default_nettype wire

// file: bench/etsq_seq_asserts.sv
`default_nettype none
module etsq_seq_asserts
(
    input wire logic i_core_clk, // Core clock.
    input wire logic i_rst, // Reset.
    input wire logic i_bus_ready, // Access done.
    input wire logic o_bus_req, // Access request.
    input wire logic o_bus_write, // Write access.
    input wire logic o_bus_lock, // Bus lock.
    input wire logic [etsq_pkg::ETSQ_DW-1:0] o_bus_addr, // Byte address.
    input wire logic [etsq_pkg::ETSQ_NCH-1:0] o_done // Completions.
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bus order checks
    // ----------------------------------------
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // Completed read and completed write.
    sequence s_rd;
        o_bus_req && !o_bus_write && i_bus_ready;
    endsequence
    sequence s_wr;
        o_bus_req && o_bus_write && i_bus_ready;
    endsequence
    AST_ALIGN: assert property (o_bus_req |-> o_bus_addr[1:0] == 2'h0)
        else $error("unaligned access");
    AST_HOLD: assert property (o_bus_req && !i_bus_ready |=> o_bus_req &&
        $stable(o_bus_addr) && $stable(o_bus_write)) else $error("request dropped");
    AST_WB: assert property (s_rd |=> s_wr or (o_bus_req && o_bus_write &&
        o_bus_lock && $stable(o_bus_addr))) else $error("no write-back");
    AST_LOCK: assert property (o_bus_req && !o_bus_write |-> o_bus_lock)
        else $error("read without lock");
    AST_END: assert property (s_wr |=> !o_bus_lock && $onehot(o_done))
        else $error("no completion");
    AST_CAUSE: assert property (|o_done |-> $past(o_bus_write && i_bus_ready))
        else $error("stray completion");
    AST_PULSE: assert property (|o_done |=> o_done == 8'h00)
        else $error("long completion");
    AST_GAP: assert property (s_wr |=> !o_bus_req [*2])
        else $error("tasks overlap");
endmodule
bind etsq_sequencer etsq_seq_asserts u_etsq_seq_asserts (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus_ready(i_bus_ready),
    .o_bus_req(o_bus_req), .o_bus_write(o_bus_write), .o_bus_lock(o_bus_lock),
    .o_bus_addr(o_bus_addr), .o_done(o_done));
`default_nettype wire

// file: bench/etsq_periph.sv
`default_nettype none
module etsq_periph
(
    input wire logic i_core_clk, // Core clock.
    input wire logic i_req, // Access request.
    input wire logic i_write, // Write access.
    input wire logic [31:0] i_addr, // Byte address.
    input wire logic [31:0] i_wdata, // Write data.
    output logic o_ready, // Access done.
    output logic [31:0] o_rdata // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 47;
    logic [31:0] mem [logic [31:0]];
    logic [31:0] wa_q [$];
    logic [31:0] wd_q [$];
    initial o_ready = 1'b0;
    initial o_rdata = 32'h0;
    // Logs writes at the handshake edge, then answers at random speed.
    always @(posedge i_core_clk)
    begin
        if (o_ready && i_req && i_write)
        begin
            mem[i_addr] = i_wdata;
            wa_q.push_back(i_addr);
            wd_q.push_back(i_wdata);
        end
        #2;
        o_ready = i_req && $random(seed) & 1;
        o_rdata = !o_ready ? ~o_rdata : mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
    end
endmodule
`default_nettype wire

// file: bench/etsq_sequencer_bench.sv
`default_nettype none
module etsq_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import etsq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ETSQ_NEXT-1:0] evt = 120'h0;
    logic [7:0] en = 8'h00, rmw = 8'h00, use_st = 8'h00, done;
    logic [7:0][6:0] sel = 56'h0;
    logic [7:0][1:0] op = 16'h0, st_idx = 16'h0;
    logic [7:0][29:0] addr = 240'h0;
    logic [7:0][31:0] data = 256'h0;
    logic st_we = 1'b0;
    logic [1:0] st_widx = 2'h0;
    logic [31:0] st_wdata = 32'h0, rdata, baddr, wdata;
    logic ready, req, wr, lock;
    logic [31:0] st [4];
    logic [31:0] mdl [logic [31:0]];
    int seed = 47;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int done_cnt = 0;
    etsq_sequencer u_etsq_sequencer (.i_core_clk(clk), .i_rst(rst), .i_evt(evt),
        .i_ch_en(en), .i_ch_sel(sel), .i_ch_rmw(rmw), .i_ch_op(op), .i_ch_addr(addr),
        .i_ch_data(data), .i_ch_use_store(use_st), .i_ch_store_idx(st_idx),
        .i_store_we(st_we), .i_store_idx(st_widx), .i_store_wdata(st_wdata),
        .i_bus_ready(ready), .i_bus_rdata(rdata), .o_bus_req(req), .o_bus_write(wr),
        .o_bus_lock(lock), .o_bus_addr(baddr), .o_bus_wdata(wdata), .o_done(done));
    etsq_periph u_etsq_periph (.i_core_clk(clk), .i_req(req), .i_write(wr),
        .i_addr(baddr), .i_wdata(wdata), .o_ready(ready), .o_rdata(rdata));
    // Clock and hang guard.
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    // Completion pulses are counted at the falling edge, where they stand.
    always @(negedge clk)
    begin
        done_cnt += $countones(done);
    end
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic [31:0] comb(input logic [1:0] o, input logic [31:0] a,
        input logic [31:0] b);
        case (o)
            2'h0: return a ^ b;
            2'h1: return a & b;
            2'h2: return a | b;
            default: return a + b;
        endcase
    endfunction
    // One round: fill store, configure, fire, then compare with the model.
    task automatic run_round(input bit chain);
        logic [31:0] a, v, r;
        logic [31:0] ea [$];
        logic [31:0] ed [$];
        int d0;
        d0 = done_cnt;
        for (int i = 0; i < 4; i++)
        begin
            st_we = 1'b1;
            st_widx = i[1:0];
            st_wdata = $random(seed);
            st[i] = st_wdata;
            tick();
        end
        st_we = 1'b0;
        r = $random(seed);
        en = chain ? 8'hFF : r[7:0];
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            sel[k] = (chain && k > 0) ? 7'(119 + k) : 7'(k * 15);
            {st_idx[k], use_st[k], op[k], rmw[k]} = r[5:0];
            addr[k] = {27'h0, r[8:6]};
            data[k] = $random(seed);
            if (en[k])
            begin
                a = {addr[k], 2'h0};
                v = use_st[k] ? st[st_idx[k]] : data[k];
                if (rmw[k])
                    v = comb(op[k], mdl.exists(a) ? mdl[a] : ~a, v);
                mdl[a] = v;
                ea.push_back(a);
                ed.push_back(v);
            end
            evt[k * 15] = 1'b1;
        end
        tick();
        evt = 120'h0;
        for (int w = 0; w < 400 && u_etsq_periph.wa_q.size() < ea.size(); w++)
            tick();
        repeat (10) tick();
        chk("write count", ea.size(), u_etsq_periph.wa_q.size());
        chk("completions", ea.size(), done_cnt - d0);
        while (ea.size() > 0 && u_etsq_periph.wa_q.size() > 0)
        begin
            chk("address", ea.pop_front(), u_etsq_periph.wa_q.pop_front());
            chk("data", ed.pop_front(), u_etsq_periph.wd_q.pop_front());
        end
        u_etsq_periph.wa_q.delete();
        u_etsq_periph.wd_q.delete();
    endtask
    // Reset, then alternate parallel and chained rounds.
    initial
    begin
        repeat (20) tick();
        rst = 1'b0;
        for (int r = 0; r < 12; r++)
            run_round(r[0]);
        stop_test();
    end
endmodule
`default_nettype wire
